// ---- src/radio_mode_consts.svh ----
/*
 * Timing constants of the operating-mode sequencer.
 * Assumes a 125 MHz mclk (8 ns period); counts are derived from times.
 */
`ifndef RADIO_MODE_CONSTS_SVH
`define RADIO_MODE_CONSTS_SVH

`define CLK_PERIOD_NS 8
`define RESET_MIN_US 1000
`define RESET_MAX_US 100000
`define RESET_CYCLES ((`RESET_MIN_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WAKEUP_SETTLE_US 1500
`define WAKEUP_REF_MH 30
`define WAKEUP_SETTLE_CYCLES ((`WAKEUP_SETTLE_US * 1000) / `CLK_PERIOD_NS)
`define ACTIVE_ENTRY_US 130
`define ACTIVE_ENTRY_CYCLES ((`ACTIVE_ENTRY_US * 1000) / `CLK_PERIOD_NS)
`define POWER_PERSIST_US 40
`define POWER_PERSIST_CYCLES ((`POWER_PERSIST_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TX_STAY_MAX_US 4000
`define TX_STAY_MAX_CYCLES ((`TX_STAY_MAX_US * 1000) / `CLK_PERIOD_NS)

`endif

// ---- src/radio_mode_pkg.sv ----
/*
 * Types shared by the operating-mode sequencer.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package radio_mode_pkg;

	// Gray codes along reset, power down, wakeup, standby-I, settle, transmit, standby-II.
	typedef enum logic [3:0] {
		ST_RESET = 4'h0,
		ST_POWER_DOWN = 4'h1,
		ST_WAKEUP = 4'h3,
		ST_STANDBY_1 = 4'h2,
		ST_SETTLE = 4'h6,
		ST_TX = 4'h7,
		ST_STANDBY_2 = 4'h5,
		ST_RX = 4'h4,
		ST_TX_SETTLE = 4'hC
	} radio_mode_t;

endpackage : radio_mode_pkg

// ---- src/radio_timer_if.sv ----
/*
 * Interface between the mode sequencer and its shared down-counter.
 * Assumes both ends run on mclk.
 */
`timescale 1ns/1ns

interface radio_timer_if;
	logic load;
	logic [23:0] value;
	logic done;

	modport ctrl (output load, output value, input done);
	modport timer (input load, input value, output done);
endinterface : radio_timer_if

// ---- src/radio_timer.sv ----
/*
 * Down-counter used for every timed wait of the mode sequencer.
 * Assumes the controller loads it and watches done.
 */
`timescale 1ns/1ns

module radio_timer (
	// Clock and reset.
	input wire logic mclk,
	input wire logic rst_n,
	// Control.
	radio_timer_if.timer tif
);

	logic [23:0] count_ff;
	logic [23:0] nxt_count;

	always_comb begin
		nxt_count = count_ff;
		if (tif.load) begin
			nxt_count = tif.value;
		end else if (count_ff != 24'h000000) begin
			nxt_count = count_ff - 24'h000001;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			count_ff <= 24'h000000;
		end else begin
			count_ff <= nxt_count;
		end
	end

	// Done is high once a loaded count has run down to one remaining cycle.
	assign tif.done = !tif.load && (count_ff <= 24'h000001);

endmodule : radio_timer

// ---- src/radio_mode_state_machine.sv ----
/*
 * Operating-mode sequencer of a packet transceiver: reset, power down, two
 * standby modes, receive and transmit, with the received-power filter.
 * Assumes all inputs are synchronous to mclk and that rst_n is the
 * supply-triggered power-on reset; packet engines sit outside and report
 * through the tx_* and rx_* strobes.
 */
`timescale 1ns/1ns
`include "radio_mode_consts.svh"

// What this block does
// - Hold reset state until power down entry.
// - Reset lasts between 1 and 100 ms.
// - Oscillator wakeup completes within 1.5 ms scaled.
// - Power down disables radio, keeps registers.
// - Cleared power bit forces power down.
// - Setting power bit enters standby-I.
// - Active only with activate high; low returns standby-I.
// - Transmitter, activate high, empty FIFO: standby-II.
// - Packet in standby-II starts synthesizer, sends after 130us.
// - Standby keeps registers and serial interface.
// - Receive needs power, receive role, activate high.
// - Valid packet needs address and CRC, stored free slot.
// - Full receive FIFO drops valid packet.
// - Receive held until host ends it or automation.
// - Power flag after 40us of strong signal.
// - After packet: low standby-I, next, or standby-II.
// - Automation caps transmit stay at 4ms.
// - Activate high sends all queued packets, retries included.
// - Standby-II transmit settle starts when chip select rises after upload.
// - Single pulse sends one packet, then standby-I.
// - Standby-I entry waits for packet completion.
// - Standby to active settles within 130us.
module radio_mode_state_machine #(
	parameter int RESET_CYCLES = `RESET_CYCLES,
	parameter int WAKEUP_CYCLES = `WAKEUP_SETTLE_CYCLES,
	parameter int ACTIVE_CYCLES = `ACTIVE_ENTRY_CYCLES,
	parameter int PERSIST_CYCLES = `POWER_PERSIST_CYCLES,
	parameter int TX_MAX_CYCLES = `TX_STAY_MAX_CYCLES,
	parameter int XTAL_MH = `WAKEUP_REF_MH
) (
	// Clock and reset.
	input wire logic mclk,
	input wire logic rst_n,
	// Host controls.
	input wire logic power_on_request_bit,
	input wire logic receive_role_select,
	input wire logic activate,
	input wire logic auto_protocol_en,
	input wire logic serial_select_n,
	// Transmit FIFO and packet engine.
	input wire logic tx_fifo_empty,
	input wire logic tx_upload,
	input wire logic tx_packet_done,
	// Receive path.
	input wire logic rx_packet,
	input wire logic rx_addr_match,
	input wire logic rx_crc_ok,
	input wire logic rx_fifo_full,
	input wire logic rx_power_above,
	// Status.
	output radio_mode_pkg::radio_mode_t mode,
	output logic in_reset,
	output logic radio_enable,
	output logic registers_writable,
	output logic synth_on,
	output logic tx_active,
	output logic tx_start,
	output logic rx_active,
	output logic rx_store,
	output logic rx_drop,
	output logic received_power_flag,
	output logic tx_timeout
);

	////////////////////////////////////////////////////////////////////////////
	// Timer and scaled wakeup count.

	localparam int WAKE_SCALED = (XTAL_MH > `WAKEUP_REF_MH) ?
		(WAKEUP_CYCLES / `WAKEUP_REF_MH) * XTAL_MH : WAKEUP_CYCLES;

	radio_timer_if tif ();

	radio_timer u_timer (
		.mclk(mclk),
		.rst_n(rst_n),
		.tif(tif)
	);

	radio_mode_pkg::radio_mode_t state_ff;
	radio_mode_pkg::radio_mode_t nxt_state;
	logic pending_ff;
	logic nxt_pending;
	logic one_shot_ff;
	logic nxt_one_shot;
	logic [23:0] tx_stay_ff;
	logic [23:0] nxt_tx_stay;
	logic upload_seen_ff;
	logic nxt_upload_seen;
	logic select_prev_ff;
	logic nxt_select_prev;
	logic start_ff;
	logic nxt_start;
	logic load;
	logic [23:0] load_value;
	logic upload_ready;
	logic tx_cap;
	logic reset_armed_ff;
	logic nxt_reset_armed;

	assign tif.load = load;
	assign tif.value = load_value;

	// The upload counts once chip select has risen to end it.
	assign upload_ready = upload_seen_ff && serial_select_n && !select_prev_ff;
	assign tx_cap = auto_protocol_en && (tx_stay_ff >= 24'(TX_MAX_CYCLES - 1));

	////////////////////////////////////////////////////////////////////////////
	// Mode state machine.

	always_comb begin
		nxt_state = state_ff;
		nxt_pending = pending_ff;
		nxt_one_shot = one_shot_ff;
		nxt_start = 1'b0;
		load = 1'b0;
		load_value = 24'h000000;
		nxt_upload_seen = upload_seen_ff;
		nxt_select_prev = serial_select_n;
		if (tx_upload) begin
			nxt_upload_seen = 1'b1;
		end
		case (state_ff)
			radio_mode_pkg::ST_RESET: begin
				if (!reset_armed_ff) begin
					load = 1'b1;
					load_value = 24'(RESET_CYCLES);
				end else if (tif.done) begin
					nxt_state = radio_mode_pkg::ST_POWER_DOWN;
				end
			end
			radio_mode_pkg::ST_POWER_DOWN: begin
				if (power_on_request_bit) begin
					nxt_state = radio_mode_pkg::ST_WAKEUP;
					load = 1'b1;
					load_value = 24'(WAKE_SCALED);
				end
			end
			radio_mode_pkg::ST_WAKEUP: begin
				if (tif.done) begin
					nxt_state = radio_mode_pkg::ST_STANDBY_1;
				end
			end
			radio_mode_pkg::ST_STANDBY_1: begin
				nxt_upload_seen = 1'b0;
				if (activate) begin
					if (receive_role_select || !tx_fifo_empty) begin
						nxt_state = radio_mode_pkg::ST_SETTLE;
						nxt_pending = receive_role_select;
						nxt_one_shot = 1'b1;
						load = 1'b1;
						load_value = 24'(ACTIVE_CYCLES);
					end else begin
						nxt_state = radio_mode_pkg::ST_STANDBY_2;
					end
				end
			end
			radio_mode_pkg::ST_STANDBY_2: begin
				if (!activate) begin
					nxt_state = radio_mode_pkg::ST_STANDBY_1;
				end else if (receive_role_select) begin
					nxt_state = radio_mode_pkg::ST_SETTLE;
					nxt_pending = 1'b1;
					load = 1'b1;
					load_value = 24'(ACTIVE_CYCLES);
				end else if (upload_ready) begin
					nxt_state = radio_mode_pkg::ST_TX_SETTLE;
					nxt_upload_seen = 1'b0;
					load = 1'b1;
					load_value = 24'(ACTIVE_CYCLES);
				end
			end
			radio_mode_pkg::ST_SETTLE,
			radio_mode_pkg::ST_TX_SETTLE: begin
				if (tif.done) begin
					if (pending_ff && state_ff == radio_mode_pkg::ST_SETTLE) begin
						nxt_state = radio_mode_pkg::ST_RX;
					end else begin
						nxt_state = radio_mode_pkg::ST_TX;
						nxt_start = 1'b1;
					end
				end
			end
			radio_mode_pkg::ST_TX: begin
				if (activate) begin
					nxt_one_shot = 1'b0;
				end
				if (tx_packet_done || tx_cap) begin
					if (!activate || (one_shot_ff && !activate)) begin
						nxt_state = radio_mode_pkg::ST_STANDBY_1;
					end else if (!tx_fifo_empty && !tx_cap) begin
						nxt_start = 1'b1;
					end else begin
						nxt_state = radio_mode_pkg::ST_STANDBY_2;
					end
				end
			end
			radio_mode_pkg::ST_RX: begin
				if (!activate) begin
					nxt_state = radio_mode_pkg::ST_STANDBY_1;
				end else if (!receive_role_select && auto_protocol_en) begin
					nxt_state = radio_mode_pkg::ST_SETTLE;
					nxt_pending = 1'b0;
					load = 1'b1;
					load_value = 24'(ACTIVE_CYCLES);
				end
			end
			default: begin
				nxt_state = radio_mode_pkg::ST_POWER_DOWN;
			end
		endcase
		// Clearing the power bit wins over every mode except reset.
		if (!power_on_request_bit && state_ff != radio_mode_pkg::ST_RESET) begin
			nxt_state = radio_mode_pkg::ST_POWER_DOWN;
			nxt_start = 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= radio_mode_pkg::ST_RESET;
			pending_ff <= 1'b0;
			one_shot_ff <= 1'b0;
			start_ff <= 1'b0;
			upload_seen_ff <= 1'b0;
			select_prev_ff <= 1'b1;
		end else begin
			state_ff <= nxt_state;
			pending_ff <= nxt_pending;
			one_shot_ff <= nxt_one_shot;
			start_ff <= nxt_start;
			upload_seen_ff <= nxt_upload_seen;
			select_prev_ff <= nxt_select_prev;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Reset timer start: the timer is loaded once on the first cycle after release.

	always_comb begin
		nxt_reset_armed = 1'b1;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			reset_armed_ff <= 1'b0;
		end else begin
			reset_armed_ff <= nxt_reset_armed;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Transmit stay counter and received-power filter.

	logic [15:0] persist_ff;
	logic [15:0] nxt_persist;
	logic flag_ff;
	logic nxt_flag;

	always_comb begin
		nxt_tx_stay = 24'h000000;
		if (state_ff == radio_mode_pkg::ST_TX && !nxt_start) begin
			nxt_tx_stay = tx_stay_ff + 24'h000001;
		end
		nxt_persist = 16'h0000;
		nxt_flag = 1'b0;
		if (state_ff == radio_mode_pkg::ST_RX) begin
			nxt_flag = flag_ff;
			if (rx_power_above) begin
				nxt_persist = persist_ff;
				if (persist_ff < 16'(PERSIST_CYCLES)) begin
					nxt_persist = persist_ff + 16'h0001;
				end
				if (persist_ff >= 16'(PERSIST_CYCLES - 1)) begin
					nxt_flag = 1'b1;
				end
			end else begin
				nxt_flag = 1'b0;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tx_stay_ff <= 24'h000000;
			persist_ff <= 16'h0000;
			flag_ff <= 1'b0;
		end else begin
			tx_stay_ff <= nxt_tx_stay;
			persist_ff <= nxt_persist;
			flag_ff <= nxt_flag;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs.

	always_comb begin
		radio_enable = state_ff == radio_mode_pkg::ST_SETTLE ||
			state_ff == radio_mode_pkg::ST_TX_SETTLE ||
			state_ff == radio_mode_pkg::ST_TX || state_ff == radio_mode_pkg::ST_RX;
	end

	assign mode = state_ff;
	assign in_reset = state_ff == radio_mode_pkg::ST_RESET;
	assign registers_writable = !in_reset;
	assign synth_on = radio_enable;
	assign tx_active = state_ff == radio_mode_pkg::ST_TX;
	assign tx_start = start_ff;
	assign rx_active = state_ff == radio_mode_pkg::ST_RX;
	assign rx_store = rx_active && rx_packet && rx_addr_match && rx_crc_ok && !rx_fifo_full;
	assign rx_drop = rx_active && rx_packet && rx_addr_match && rx_crc_ok && rx_fifo_full;
	assign received_power_flag = flag_ff;
	assign tx_timeout = tx_active && tx_cap;

endmodule : radio_mode_state_machine

// ---- test/host_model.sv ----
/* Host side of the activate pin: a level hold plus a timed pulse.
   Assumes the bench requests pulses on mclk. */
`timescale 1ns/1ns
module host_model #(
	parameter int PULSE_CYCLES = 12
) (
	// Clock and reset.
	input wire logic mclk,
	input wire logic rst_n,
	// Requests from the bench.
	input wire logic hold,
	input wire logic fire,
	// Pin.
	output logic activate
);
	int left;
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			left <= 0;
		end else if (fire) begin
			left <= PULSE_CYCLES;
		end else if (left > 0) begin
			left <= left - 1;
		end
	end
	assign activate = hold || left > 0;
endmodule : host_model

// ---- test/radio_mode_monitor.sv ----
/* Port checker of the mode sequencer.
   Assumes it is bound into radio_mode_state_machine. */
`timescale 1ns/1ns
module radio_mode_monitor #(
	parameter int WAKEUP_CYCLES = 8,
	parameter int ACTIVE_CYCLES = 8,
	parameter int PERSIST_CYCLES = 8
) (
	// Clock and reset.
	input wire logic mclk,
	input wire logic rst_n,
	// Inputs.
	input wire logic power_on_request_bit,
	input wire logic receive_role_select,
	input wire logic activate,
	input wire logic tx_packet_done,
	input wire logic rx_packet,
	input wire logic rx_addr_match,
	input wire logic rx_crc_ok,
	input wire logic rx_fifo_full,
	input wire logic rx_power_above,
	// Outputs.
	input radio_mode_pkg::radio_mode_t mode,
	input wire logic radio_enable,
	input wire logic registers_writable,
	input wire logic tx_start,
	input wire logic rx_store,
	input wire logic rx_drop,
	input wire logic received_power_flag
);
	localparam int WAKE_MAX = WAKEUP_CYCLES + 4;
	localparam int ACT_MAX = ACTIVE_CYCLES + 4;
	logic [7:0] above_ff;
	logic [7:0] nxt_above;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////
	// Counts consecutive strong-signal cycles, saturating.
	always_comb begin
		nxt_above = !rx_power_above ? 8'h00 : (&above_ff ? above_ff : above_ff + 8'h01);
	end
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			above_ff <= 8'h00;
		end else begin
			above_ff <= nxt_above;
		end
	end
	////////////////////////////////////////
	property p_power_down;
		!power_on_request_bit && mode != radio_mode_pkg::ST_RESET
			|=> mode == radio_mode_pkg::ST_POWER_DOWN;
	endproperty
	a_power_down: assert property (p_power_down) else $error("power down missed");
	property p_rx_entry;
		mode != radio_mode_pkg::ST_RX ##1 mode == radio_mode_pkg::ST_RX
			|-> $past(power_on_request_bit) && $past(receive_role_select) && $past(activate);
	endproperty
	a_rx_entry: assert property (p_rx_entry) else $error("bad receive entry");
	property p_store;
		rx_packet && rx_addr_match && rx_crc_ok && !rx_fifo_full
			&& mode == radio_mode_pkg::ST_RX |-> rx_store && !rx_drop;
	endproperty
	a_store: assert property (p_store) else $error("valid packet not stored");
	property p_drop;
		rx_packet && rx_addr_match && rx_crc_ok && rx_fifo_full
			&& mode == radio_mode_pkg::ST_RX |-> rx_drop && !rx_store;
	endproperty
	a_drop: assert property (p_drop) else $error("full fifo packet not dropped");
	property p_wake;
		mode == radio_mode_pkg::ST_WAKEUP |-> ##[1:WAKE_MAX] mode != radio_mode_pkg::ST_WAKEUP;
	endproperty
	a_wake: assert property (p_wake) else $error("wakeup too long");
	property p_settle;
		mode == radio_mode_pkg::ST_SETTLE |-> ##[1:ACT_MAX] mode != radio_mode_pkg::ST_SETTLE;
	endproperty
	a_settle: assert property (p_settle) else $error("settle too long");
	property p_tx_start;
		mode == radio_mode_pkg::ST_TX && $past(mode) != radio_mode_pkg::ST_TX |-> ##[0:1] tx_start;
	endproperty
	a_tx_start: assert property (p_tx_start) else $error("no start pulse");
	property p_tx_end;
		mode == radio_mode_pkg::ST_TX && tx_packet_done && !activate && power_on_request_bit
			|=> mode == radio_mode_pkg::ST_STANDBY_1;
	endproperty
	a_tx_end: assert property (p_tx_end) else $error("no standby after packet");
	property p_power_flag;
		$rose(received_power_flag) |-> int'(above_ff) >= PERSIST_CYCLES - 1;
	endproperty
	a_power_flag: assert property (p_power_flag) else $error("power flag too early");
	property p_regs;
		mode inside {radio_mode_pkg::ST_POWER_DOWN, radio_mode_pkg::ST_STANDBY_1,
			radio_mode_pkg::ST_STANDBY_2} |-> registers_writable
			&& (mode != radio_mode_pkg::ST_POWER_DOWN || !radio_enable);
	endproperty
	a_regs: assert property (p_regs) else $error("idle mode access wrong");
endmodule : radio_mode_monitor

bind radio_mode_state_machine radio_mode_monitor #(.WAKEUP_CYCLES(WAKEUP_CYCLES),
	.ACTIVE_CYCLES(ACTIVE_CYCLES), .PERSIST_CYCLES(PERSIST_CYCLES)) radio_mode_monitor_i (
	.mclk, .rst_n, .power_on_request_bit, .receive_role_select, .activate, .tx_packet_done,
	.rx_packet, .rx_addr_match, .rx_crc_ok, .rx_fifo_full, .rx_power_above, .mode,
	.radio_enable, .registers_writable, .tx_start, .rx_store, .rx_drop, .received_power_flag);

// ---- test/radio_mode_state_machine_tb_top.sv ----
/* Bench of the mode sequencer with shortened timing.
   Assumes host_model and the bound monitor. */
`timescale 1ns/1ns
module radio_mode_state_machine_tb_top;
	logic mclk, rst_n, power_on_request_bit, receive_role_select, activate, auto_protocol_en;
	logic serial_select_n, tx_fifo_empty, tx_upload, tx_packet_done, rx_packet, rx_addr_match;
	logic rx_crc_ok, rx_fifo_full, rx_power_above, hold, fire, in_reset, radio_enable;
	logic registers_writable, synth_on, tx_active, tx_start, rx_active, rx_store, rx_drop;
	logic received_power_flag, tx_timeout;
	radio_mode_pkg::radio_mode_t mode;
	int mismatches = 0;
	int num_checks = 0;
	radio_mode_state_machine #(.RESET_CYCLES(16), .WAKEUP_CYCLES(8), .ACTIVE_CYCLES(8),
		.PERSIST_CYCLES(8), .TX_MAX_CYCLES(40)) radio_mode_state_machine_i (.mclk, .rst_n,
		.power_on_request_bit, .receive_role_select, .activate, .auto_protocol_en,
		.serial_select_n, .tx_fifo_empty, .tx_upload, .tx_packet_done, .rx_packet,
		.rx_addr_match, .rx_crc_ok, .rx_fifo_full, .rx_power_above, .mode, .in_reset,
		.radio_enable, .registers_writable, .synth_on, .tx_active, .tx_start, .rx_active,
		.rx_store, .rx_drop, .received_power_flag, .tx_timeout);
	host_model #(.PULSE_CYCLES(12)) host_model_i (.mclk, .rst_n, .hold, .fire, .activate);
	////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic summarize;
		$display("checks=%0d mismatches=%0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : summarize
	task automatic wait_mode(input radio_mode_pkg::radio_mode_t m, input int n);
		for (int i = 0; i < n && mode !== m; i++) begin
			@(posedge mclk);
			#1;
		end
		check(mode, m);
		if (mode !== m) begin
			summarize();
		end
	endtask : wait_mode
	task automatic packet_done;
		@(posedge mclk);
		tx_packet_done <= 1'b1;
		@(posedge mclk);
		tx_packet_done <= 1'b0;
	endtask : packet_done
	task automatic rx_try(input logic adr, input logic full, input logic crc, input logic st,
		input logic dr);
		@(posedge mclk);
		rx_packet <= 1'b1;
		rx_addr_match <= adr;
		rx_crc_ok <= crc;
		rx_fifo_full <= full;
		#1;
		check({rx_store, rx_drop}, {st, dr});
		@(posedge mclk);
		rx_packet <= 1'b0;
	endtask : rx_try
	////////////////////////////////////////
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	initial begin
		repeat (20000) @(posedge mclk);
		mismatches++;
		summarize();
	end
	initial begin
		{rst_n, power_on_request_bit, receive_role_select, auto_protocol_en, tx_upload} = '0;
		{tx_packet_done, rx_packet, rx_addr_match, rx_crc_ok, rx_fifo_full} = '0;
		{rx_power_above, hold, fire} = '0;
		serial_select_n = 1'b1;
		tx_fifo_empty = 1'b1;
		repeat (4) @(posedge mclk);
		#1;
		check({mode, in_reset}, {radio_mode_pkg::ST_RESET, 1'b1});
		@(posedge mclk);
		rst_n <= 1'b1;
		repeat (8) @(posedge mclk);
		#1;
		check(mode, radio_mode_pkg::ST_RESET);
		wait_mode(radio_mode_pkg::ST_POWER_DOWN, 40);
		@(posedge mclk);
		power_on_request_bit <= 1'b1;
		wait_mode(radio_mode_pkg::ST_WAKEUP, 3);
		wait_mode(radio_mode_pkg::ST_STANDBY_1, 20);
		$display("power up test done");
		@(posedge mclk);
		tx_fifo_empty <= 1'b0;
		fire <= 1'b1;
		@(posedge mclk);
		fire <= 1'b0;
		wait_mode(radio_mode_pkg::ST_TX, 20);
		repeat (12) @(posedge mclk);
		tx_fifo_empty <= 1'b1;
		packet_done();
		wait_mode(radio_mode_pkg::ST_STANDBY_1, 2);
		$display("single pulse test done");
		@(posedge mclk);
		hold <= 1'b1;
		wait_mode(radio_mode_pkg::ST_STANDBY_2, 20);
		repeat (4) @(posedge mclk);
		serial_select_n <= 1'b0;
		tx_upload <= 1'b1;
		tx_fifo_empty <= 1'b0;
		@(posedge mclk);
		tx_upload <= 1'b0;
		repeat (3) @(posedge mclk);
		#1;
		check(mode, radio_mode_pkg::ST_STANDBY_2);
		@(posedge mclk);
		serial_select_n <= 1'b1;
		wait_mode(radio_mode_pkg::ST_TX, 20);
		packet_done();
		#1;
		check(mode, radio_mode_pkg::ST_TX);
		@(posedge mclk);
		tx_fifo_empty <= 1'b1;
		packet_done();
		wait_mode(radio_mode_pkg::ST_STANDBY_2, 2);
		@(posedge mclk);
		hold <= 1'b0;
		wait_mode(radio_mode_pkg::ST_STANDBY_1, 2);
		$display("held activate test done");
		@(posedge mclk);
		receive_role_select <= 1'b1;
		hold <= 1'b1;
		wait_mode(radio_mode_pkg::ST_RX, 20);
		check({rx_active, synth_on, tx_active}, 3'h6);
		rx_try(1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
		rx_try(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
		rx_try(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
		rx_try(1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
		@(posedge mclk);
		rx_power_above <= 1'b1;
		repeat (4) @(posedge mclk);
		#1;
		check(received_power_flag, 1'b0);
		repeat (12) @(posedge mclk);
		#1;
		check({received_power_flag, mode}, {1'b1, radio_mode_pkg::ST_RX});
		$display("receive test done");
		@(posedge mclk);
		auto_protocol_en <= 1'b1;
		receive_role_select <= 1'b0;
		wait_mode(radio_mode_pkg::ST_SETTLE, 3);
		wait_mode(radio_mode_pkg::ST_TX, 20);
		repeat (38) @(posedge mclk);
		#1;
		check({tx_timeout, tx_active}, 2'h1);
		@(posedge mclk);
		#1;
		check({tx_timeout, tx_active}, 2'h3);
		wait_mode(radio_mode_pkg::ST_STANDBY_2, 2);
		$display("transmit cap test done");
		@(posedge mclk);
		power_on_request_bit <= 1'b0;
		wait_mode(radio_mode_pkg::ST_POWER_DOWN, 2);
		check({radio_enable, synth_on, rx_active, registers_writable}, 4'h1);
		$display("power down test done");
		summarize();
	end
endmodule : radio_mode_state_machine_tb_top
